// >>> hw/fpb_regs.sv
// Staged frame period and shutter bound registers with activation on the slowest-frame upper write
`timescale 1ns/1ps
`include "fpb_map.svh"
module fpb_regs #(
  parameter int SETTLE_FRAMES = `FPB_SETTLE_FRAMES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_hit,
  input  wire logic        frame_tick,
  output logic      [15:0] slow_len_bits,
  output logic      [15:0] fast_len_bits,
  output logic      [15:0] exposure_cap_bits,
  output logic             settling
);
  // The settle counter is eight bits wide and needs at least one frame
  if (SETTLE_FRAMES < 1 || SETTLE_FRAMES > 255) begin : g_settle_check
    $error("SETTLE_FRAMES out of range");
  end

  // Active bounds after reset, upper byte first
  localparam logic [15:0] RST_SLOW = {`FPB_RST_SLOW_HI, `FPB_RST_SLOW_LO};
  localparam logic [15:0] RST_FAST = {`FPB_RST_FAST_HI, `FPB_RST_FAST_LO};
  localparam logic [15:0] RST_EXP  = {`FPB_RST_EXP_HI, `FPB_RST_EXP_LO};

  function automatic fpb_pkg::fpb_sel_t decode(input logic [7:0] a);
    case (a)
      `FPB_ADDR_SLOW_LO: decode = fpb_pkg::FPB_SLOW_LO;
      `FPB_ADDR_SLOW_HI: decode = fpb_pkg::FPB_SLOW_HI;
      `FPB_ADDR_FAST_LO: decode = fpb_pkg::FPB_FAST_LO;
      `FPB_ADDR_FAST_HI: decode = fpb_pkg::FPB_FAST_HI;
      `FPB_ADDR_EXP_LO:  decode = fpb_pkg::FPB_EXP_LO;
      `FPB_ADDR_EXP_HI:  decode = fpb_pkg::FPB_EXP_HI;
      default:           decode = fpb_pkg::FPB_NONE;
    endcase
  endfunction : decode

  fpb_pkg::fpb_sel_t   sel;
  fpb_pkg::fpb_state_t state_r;
  fpb_pkg::fpb_state_t state_nxt;
  logic [47:0]         staged;
  logic                act_wr;
  logic [7:0]          frames_r;
  logic [7:0]          frames_nxt;
  logic                mapped;
  logic                mem_wr_en;
  logic [2:0]          mem_wr_idx;
  logic [2:0]          mem_rd_idx;
  logic [15:0]         staged_slow;
  logic [15:0]         staged_fast;
  logic [15:0]         staged_exp;
  logic                frame_last;

  assign sel    = decode(reg_addr);
  // Completion of the slowest pair write is its upper-byte write
  assign act_wr = reg_wr && (sel == fpb_pkg::FPB_SLOW_HI);
  assign mapped      = (sel != fpb_pkg::FPB_NONE);
  assign mem_wr_en   = reg_wr && mapped;
  assign mem_wr_idx  = 3'(sel);
  // An idle read index returns zero, so read data stand only after a read
  assign mem_rd_idx  = reg_rd ? 3'(sel) : 3'(fpb_pkg::FPB_NONE);
  assign staged_slow = staged[15:0];
  assign staged_fast = staged[31:16];
  assign staged_exp  = staged[47:32];
  assign frame_last  = (frames_r + 8'h01) >= 8'(SETTLE_FRAMES);

  fpb_staging_mem u_mem (
    .clk       (clk),
    .rst       (rst),
    .wr_en     (mem_wr_en),
    .wr_idx    (mem_wr_idx),
    .wr_data   (reg_wdata),
    .rd_idx    (mem_rd_idx),
    .rd_data   (reg_rdata),
    .all_bytes (staged)
  );

  // Settling counts whole frames after activation
  always_comb begin
    state_nxt  = state_r;
    frames_nxt = frames_r;
    case (state_r)
      fpb_pkg::FPB_IDLE: begin
        if (act_wr) begin
          state_nxt  = fpb_pkg::FPB_SETTLE;
          frames_nxt = 8'h00;
        end
      end
      fpb_pkg::FPB_SETTLE: begin
        if (frame_tick) begin
          frames_nxt = frames_r + 8'h01;
          if (frame_last) begin
            state_nxt = fpb_pkg::FPB_IDLE;
          end
        end
      end
      default: state_nxt = fpb_pkg::FPB_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r  <= fpb_pkg::FPB_IDLE;
      frames_r <= 8'h00;
      settling <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      frames_r <= frames_nxt;
      settling <= (state_nxt == fpb_pkg::FPB_SETTLE);
    end
  end

  // Active bounds update once the staged bytes hold the upper write
  logic apply_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      apply_r           <= 1'b0;
      slow_len_bits     <= RST_SLOW;
      fast_len_bits     <= RST_FAST;
      exposure_cap_bits <= RST_EXP;
    end else begin
      apply_r <= act_wr;
      if (apply_r) begin
        slow_len_bits     <= staged_slow;
        fast_len_bits     <= staged_fast;
        exposure_cap_bits <= staged_exp;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_hit <= 1'b0;
    end else begin
      reg_hit <= (reg_rd || reg_wr) && mapped;
    end
  end

  // Staging, activation, settling and read data checks
  AST_APPLY_TWO: assert property (@(posedge clk) disable iff (rst)
    act_wr |-> ##2 (slow_len_bits == $past(staged[15:0], 1) && fast_len_bits == $past(staged[31:16], 1)))
    else $error("bounds not applied after activation");
  AST_HOLD: assert property (@(posedge clk) disable iff (rst)
    !apply_r |=> $stable(exposure_cap_bits) && $stable(fast_len_bits) && $stable(slow_len_bits))
    else $error("bounds changed without activation");
  AST_SETTLE_START: assert property (@(posedge clk) disable iff (rst)
    act_wr && state_r == fpb_pkg::FPB_IDLE |=> settling)
    else $error("settling not started");
  AST_SETTLE_END: assert property (@(posedge clk) disable iff (rst)
    settling && frame_tick && frames_r == 8'(SETTLE_FRAMES - 1) |=> !settling)
    else $error("settling overran");

  // Write of the fastest low byte, then a read of it in the next cycle
  sequence s_fast_lo_wr;
    reg_wr && sel == fpb_pkg::FPB_FAST_LO;
  endsequence
  sequence s_fast_lo_rd;
    reg_rd && !reg_wr && sel == fpb_pkg::FPB_FAST_LO;
  endsequence
  AST_READBACK: assert property (@(posedge clk) disable iff (rst)
    s_fast_lo_wr ##1 s_fast_lo_rd |=> reg_rdata == $past(reg_wdata, 2))
    else $error("readback of staged byte wrong");
  AST_RD_IDLE: assert property (@(posedge clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside a read");
  AST_STORE_EXP_HI: assert property (@(posedge clk) disable iff (rst)
    reg_wr && sel == fpb_pkg::FPB_EXP_HI |=> staged_exp[15:8] == $past(reg_wdata))
    else $error("exposure cap upper byte not stored");
  AST_STORE_SLOW_LO: assert property (@(posedge clk) disable iff (rst)
    reg_wr && sel == fpb_pkg::FPB_SLOW_LO |=> staged_slow[7:0] == $past(reg_wdata))
    else $error("slowest length lower byte not stored");
  AST_STORE_FAST_HI: assert property (@(posedge clk) disable iff (rst)
    reg_wr && sel == fpb_pkg::FPB_FAST_HI |=> staged_fast[15:8] == $past(reg_wdata))
    else $error("fastest length upper byte not stored");
  AST_HIT: assert property (@(posedge clk) disable iff (rst)
    reg_rd || reg_wr |=> reg_hit == $past(mapped))
    else $error("access flag wrong");

  // Activation is the upper slowest write followed by the apply strobe
  sequence s_activate;
    act_wr ##1 apply_r;
  endsequence
  AST_APPLY_SLOW: assert property (@(posedge clk) disable iff (rst)
    s_activate |=> slow_len_bits == $past(staged_slow))
    else $error("slowest length not applied");
  AST_APPLY_FAST: assert property (@(posedge clk) disable iff (rst)
    s_activate |=> fast_len_bits == $past(staged_fast))
    else $error("fastest length not applied");
  AST_EXP_APPLY: assert property (@(posedge clk) disable iff (rst)
    act_wr |-> ##2 exposure_cap_bits == $past(staged_exp, 1))
    else $error("exposure cap not applied after activation");
  AST_SETTLE_HOLD: assert property (@(posedge clk) disable iff (rst)
    settling && !frame_tick |=> settling)
    else $error("settling ended without a frame");
  AST_SETTLE_CAUSE: assert property (@(posedge clk) disable iff (rst)
    $rose(settling) |-> $past(act_wr))
    else $error("settling started without activation");
  AST_NO_WRAP: assert property (@(posedge clk) disable iff (rst)
    settling |-> frames_r < 8'(SETTLE_FRAMES))
    else $error("settle count past its end");
endmodule : fpb_regs

// >>> hw/fpb_map.svh
// Register map, reset values and timing counts of the frame period bound registers
`ifndef FPB_MAP_SVH
`define FPB_MAP_SVH
`define FPB_ADDR_SLOW_LO   8'h1a
`define FPB_ADDR_SLOW_HI   8'h1b
`define FPB_ADDR_FAST_LO   8'h1c
`define FPB_ADDR_FAST_HI   8'h1d
`define FPB_ADDR_EXP_LO    8'h1e
`define FPB_ADDR_EXP_HI    8'h1f
`define FPB_RST_SLOW_LO    8'hc0
`define FPB_RST_SLOW_HI    8'h5d
`define FPB_RST_FAST_LO    8'ha0
`define FPB_RST_FAST_HI    8'h0f
`define FPB_RST_EXP_LO     8'h20
`define FPB_RST_EXP_HI     8'h4e
`define FPB_SETTLE_FRAMES  2
`define FPB_BYTE_HI        15:8
`define FPB_BYTE_LO        7:0
`endif

// >>> hw/fpb_pkg.sv
// Types shared by the frame period bound register files
package fpb_pkg;
  typedef enum logic [2:0] {
    FPB_SLOW_LO, FPB_SLOW_HI, FPB_FAST_LO, FPB_FAST_HI, FPB_EXP_LO, FPB_EXP_HI, FPB_NONE
  } fpb_sel_t;
  typedef enum logic [1:0] {
    FPB_IDLE, FPB_SETTLE
  } fpb_state_t;
endpackage : fpb_pkg

// >>> hw/fpb_staging_mem.sv
// Six-byte staging store for written bound bytes, registered read data
`timescale 1ns/1ps
`include "fpb_map.svh"
module fpb_staging_mem (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wr_en,
  input  wire logic [2:0] wr_idx,
  input  wire logic [7:0] wr_data,
  input  wire logic [2:0] rd_idx,
  output logic      [7:0] rd_data,
  output logic     [47:0] all_bytes
);
  logic [7:0] mem_r [6];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_r[0] <= `FPB_RST_SLOW_LO;
      mem_r[1] <= `FPB_RST_SLOW_HI;
      mem_r[2] <= `FPB_RST_FAST_LO;
      mem_r[3] <= `FPB_RST_FAST_HI;
      mem_r[4] <= `FPB_RST_EXP_LO;
      mem_r[5] <= `FPB_RST_EXP_HI;
      rd_data  <= 8'h00;
    end else begin
      if (wr_en && wr_idx < 3'h6) begin
        mem_r[wr_idx] <= wr_data;
      end
      rd_data <= (rd_idx < 3'h6) ? mem_r[rd_idx] : 8'h00;
    end
  end
  assign all_bytes = {mem_r[5], mem_r[4], mem_r[3], mem_r[2], mem_r[1], mem_r[0]};
endmodule : fpb_staging_mem

// >>> verification/fpb_host_model.sv
// Microcontroller model that moves bound pairs over the byte register port
`timescale 1ns/1ps
module fpb_host_model (
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // One byte access; released address and data lines show the inverse, never the old value, and both strobes drop to zero
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk) #1;
    reg_wr    = wr;
    reg_rd    = !wr;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk) #1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
    q         = reg_rdata;
  endtask : acc
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    logic [7:0] q;
    acc(1'b1, a, v[7:0], q);
    acc(1'b1, a + 8'h01, v[15:8], q);
  endtask : wr16
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    acc(1'b0, a + 8'h01, 8'h00, v[15:8]);
    acc(1'b0, a, 8'h00, v[7:0]);
  endtask : rd16
  // Write a byte and read it back in the very next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk) #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk) #1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b1;
    reg_wdata = ~d;
    @(posedge clk) #1;
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    q         = reg_rdata;
  endtask : wr_rd
endmodule : fpb_host_model

// >>> verification/test_fpb_regs.sv
// Self-checking bench for the staged frame period bound registers
`timescale 1ns/1ps
`include "fpb_map.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t mismatch", $time); end end
module test_fpb_regs;
  logic        clk, rst, reg_wr, reg_rd, reg_hit, frame_tick, settling;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, q;
  logic [15:0] slow_len_bits, fast_len_bits, exposure_cap_bits, v;
  int          n_errors;
  int          tests_run;
  fpb_regs i_fpb_regs (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .frame_tick(frame_tick),
    .slow_len_bits(slow_len_bits), .fast_len_bits(fast_len_bits), .exposure_cap_bits(exposure_cap_bits),
    .settling(settling));
  fpb_host_model i_fpb_host_model (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  task automatic print_verdict;
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic check_reset;
    `CHK(slow_len_bits, {`FPB_RST_SLOW_HI, `FPB_RST_SLOW_LO})
    `CHK(fast_len_bits, {`FPB_RST_FAST_HI, `FPB_RST_FAST_LO})
    `CHK(exposure_cap_bits, {`FPB_RST_EXP_HI, `FPB_RST_EXP_LO})
    i_fpb_host_model.rd16(`FPB_ADDR_SLOW_LO, v);
    `CHK(v, {`FPB_RST_SLOW_HI, `FPB_RST_SLOW_LO})
  endtask : check_reset
  task automatic check_staging;
    i_fpb_host_model.wr16(`FPB_ADDR_FAST_LO, 16'h1980);
    i_fpb_host_model.wr16(`FPB_ADDR_EXP_LO, 16'h1000);
    repeat (3) @(posedge clk) #1;
    `CHK({fast_len_bits, exposure_cap_bits}, 32'h0fa0_4e20)
    i_fpb_host_model.rd16(`FPB_ADDR_FAST_LO, v);
    `CHK(v, 16'h1980)
    i_fpb_host_model.rd16(`FPB_ADDR_EXP_LO, v);
    `CHK(v, 16'h1000)
    i_fpb_host_model.wr16(`FPB_ADDR_SLOW_LO, 16'h61a8);
    @(posedge clk) #1;
    `CHK(settling, 1'b1)
    @(posedge clk) #1;
    `CHK({slow_len_bits, fast_len_bits, exposure_cap_bits}, 48'h61a8_1980_1000)
    repeat (2) begin
      `CHK(settling, 1'b1)
      frame_tick = 1'b1;
      @(posedge clk) #1;
      frame_tick = 1'b0;
      @(posedge clk) #1;
    end
    @(posedge clk) #1;
    `CHK(settling, 1'b0)
  endtask : check_staging
  task automatic check_readback;
    i_fpb_host_model.wr_rd(`FPB_ADDR_FAST_LO, 8'h5a, q);
    `CHK(q, 8'h5a)
    `CHK(fast_len_bits, 16'h1980)
  endtask : check_readback
  task automatic check_unmapped;
    i_fpb_host_model.acc(1'b0, 8'h30, 8'h00, q);
    `CHK({q, reg_hit}, 9'h000)
    i_fpb_host_model.acc(1'b0, `FPB_ADDR_EXP_HI, 8'h00, q);
    `CHK({q, reg_hit}, 9'h021)
  endtask : check_unmapped
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rst        = 1'b1;
    frame_tick = 1'b0;
    n_errors   = 0;
    tests_run  = 0;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    check_reset();
    check_staging();
    check_readback();
    check_unmapped();
    print_verdict();
  end
  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end
endmodule : test_fpb_regs
